// [src/ead_defines.svh]
// constants of the event action dispatcher
`ifndef EAD_DEFINES_SVH
`define EAD_DEFINES_SVH

`define EAD_NUM_EVT      14
`define EAD_NUM_TMR      8
`define EAD_NUM_INT      4

// register indices
`define EAD_REG_LINE_A   8'h23
`define EAD_REG_LINE_D   8'h26
`define EAD_REG_BOOT     8'h27
`define EAD_REG_JOIN     8'h28
`define EAD_REG_THR_BASE 8'h29
`define EAD_REG_THR_LAST 8'h30
`define EAD_REG_ACT_BASE 8'h31
`define EAD_REG_ACT_LAST 8'h38

// event positions
`define EAD_EVT_LINE_C   2
`define EAD_EVT_BOOT     4
`define EAD_EVT_JOIN     5
`define EAD_EVT_TMR0     6

// reset values
`define EAD_RST_LINE_A   16'h0001
`define EAD_RST_NONE     16'h0000
`define EAD_RST_NET_THR  16'h0004
`define EAD_RST_NET_ACT  16'h0001
`define EAD_NUM_NET_TMR  4

// timing
`define EAD_TICK_MS      250
`define EAD_CLK_MHZ      200
`define EAD_TICK_CYCLES  (`EAD_TICK_MS * 1000 * `EAD_CLK_MHZ)

`endif

// [src/ead_pkg.sv]
// types of the event action dispatcher
package ead_pkg;
  typedef logic [15:0]       ead_code_t;
  typedef ead_code_t [13:0]  ead_act_arr_t;
  typedef ead_code_t [7:0]   ead_thr_arr_t;

  typedef struct packed {
    ead_act_arr_t act;
    ead_thr_arr_t thr;
    logic [3:0]   int_prev;
    logic         booted;
    logic [13:0]  evt;
    ead_code_t    rdata;
    logic         ack;
  } ead_top_st_t;

  typedef struct packed {
    logic [31:0]  presc;
    ead_thr_arr_t cnt;
    logic [7:0]   hit;
  } ead_tmr_st_t;

  typedef struct packed {
    logic [13:0]  pend;
    logic         valid;
    ead_code_t    code;
    logic [3:0]   evt;
  } ead_arb_st_t;
endpackage

// [src/ead_evt_if.sv]
// event pulses and action table toward the arbiter
`timescale 1ns/1ps
interface ead_evt_if;
  logic [13:0]          hit;
  ead_pkg::ead_act_arr_t act;
  modport drv (output hit, output act);
  modport arb (input hit, input act);
endinterface

// [src/ead_tick_timer.sv]
// eight quarter second timers with thresholds
`timescale 1ns/1ps
`include "ead_defines.svh"
module ead_tick_timer #(
  parameter int unsigned TICK_CYCLES = `EAD_TICK_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire ead_pkg::ead_thr_arr_t thr,
  output logic [7:0]                hit
);
  ead_pkg::ead_tmr_st_t q;
  ead_pkg::ead_tmr_st_t d;
  logic                 tick;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.hit = 8'h00;
    tick = (q.presc == 32'(TICK_CYCLES - 1));
    d.presc = tick ? 32'h0000_0000 : q.presc + 32'h0000_0001;
    for (int i = 0; i < `EAD_NUM_TMR; i++) begin
      if (thr[i] == 16'h0000) begin
        d.cnt[i] = 16'h0000;
      end else if (tick) begin
        if (q.cnt[i] + 16'h0001 == thr[i]) begin
          d.hit[i] = 1'b1;
          d.cnt[i] = 16'h0000;
        end else begin
          d.cnt[i] = q.cnt[i] + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hit = q.hit;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_hit_on_tick;
    d.hit != 8'h00 |-> tick;
  endproperty
  a_hit_on_tick: assert property (p_hit_on_tick)
    else $error("timer fired between ticks");

  property p_thr_zero_quiet;
    (thr[0] == 16'h0000) |=> !hit[0];
  endproperty
  a_thr_zero_quiet: assert property (p_thr_zero_quiet)
    else $error("timer with zero threshold fired");
endmodule

// [src/ead_event_arbiter.sv]
// pending event flags and action dispatch
`timescale 1ns/1ps
`include "ead_defines.svh"
module ead_event_arbiter (
  input  wire logic   clock,
  input  wire logic   rstn,
  ead_evt_if.arb      ev,
  output logic        action_valid,
  output logic [15:0] action_code,
  output logic [3:0]  action_event
);
  ead_pkg::ead_arb_st_t q;
  ead_pkg::ead_arb_st_t d;
  logic [3:0]           sel;

  function automatic logic [3:0] first_set(input logic [13:0] v);
    first_set = 4'hF;
    for (int i = `EAD_NUM_EVT - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.valid = 1'b0;
    sel = first_set(q.pend);
    if (q.pend != 14'h0000) begin
      d.pend[sel] = 1'b0;
      if (ev.act[sel] != 16'h0000) begin
        d.valid = 1'b1;
        d.code = ev.act[sel];
        d.evt = sel;
      end
    end
    d.pend = d.pend | ev.hit; // set wins over clear
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign action_valid = q.valid;
  assign action_code  = q.code;
  assign action_event = q.evt;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  property p_zero_no_action;
    action_valid |-> action_code != 16'h0000;
  endproperty
  a_zero_no_action: assert property (p_zero_no_action)
    else $error("action issued with zero code");

  property p_dispatch_code;
    (q.pend != 14'h0000 && ev.act[first_set(q.pend)] != 16'h0000)
      |=> action_valid && action_code == $past(ev.act[first_set(q.pend)]);
  endproperty
  a_dispatch_code: assert property (p_dispatch_code)
    else $error("pending event not dispatched with current code");

  property p_set_wins;
    ev.hit[0] |=> q.pend[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost");
endmodule

// [src/event_action_dispatcher.sv]
// top of the event action dispatcher with its s registers
`timescale 1ns/1ps
`include "ead_defines.svh"
module event_action_dispatcher #(
  parameter int unsigned TICK_CYCLES = `EAD_TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [3:0]  ext_int_line,
  input  wire logic [3:0]  interrupt_enable_config,
  input  wire logic        long_range_variant,
  input  wire logic        restart,
  input  wire logic        network_joined,
  input  wire logic [7:0]  reg_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_ack,
  output logic             action_valid,
  output logic [15:0]      action_code,
  output logic [3:0]       action_event
);
  ead_pkg::ead_top_st_t q;
  ead_pkg::ead_top_st_t d;
  logic [7:0]           tmr_hit;
  logic [3:0]           int_ev;
  logic [3:0]           line_mask;
  logic [4:0]           wr_act;
  logic [3:0]           wr_thr;
  logic [4:0]           rd_act;
  logic [3:0]           rd_thr;
  ead_evt_if            evt_bus ();

  // action slot of a register index, 5'h1F when none
  function automatic logic [4:0] act_slot(input logic [7:0] sel);
    if (sel >= `EAD_REG_LINE_A && sel <= `EAD_REG_JOIN) begin
      act_slot = 5'(sel - `EAD_REG_LINE_A);
    end else if (sel >= `EAD_REG_ACT_BASE && sel <= `EAD_REG_ACT_LAST) begin
      act_slot = 5'(sel - `EAD_REG_ACT_BASE + `EAD_EVT_TMR0);
    end else begin
      act_slot = 5'h1F;
    end
  endfunction

  // threshold slot of a register index, 4'hF when none
  function automatic logic [3:0] thr_slot(input logic [7:0] sel);
    if (sel >= `EAD_REG_THR_BASE && sel <= `EAD_REG_THR_LAST) begin
      thr_slot = 4'(sel - `EAD_REG_THR_BASE);
    end else begin
      thr_slot = 4'hF;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register access and event collection
  always_comb begin
    d = q;
    wr_act = act_slot(reg_sel);
    wr_thr = thr_slot(reg_sel);
    rd_act = wr_act;
    rd_thr = wr_thr;
    d.ack = reg_wr | reg_rd;
    d.rdata = 16'h0000;
    if (reg_rd) begin
      if (rd_act != 5'h1F) begin
        d.rdata = q.act[rd_act];
      end else if (rd_thr != 4'hF) begin
        d.rdata = q.thr[rd_thr[2:0]];
      end
    end
    if (reg_wr) begin
      if (wr_act != 5'h1F) begin
        d.act[wr_act] = reg_wdata;
      end else if (wr_thr != 4'hF) begin
        d.thr[wr_thr[2:0]] = reg_wdata;
      end
    end
    line_mask = long_range_variant ? 4'hB : 4'hF;
    int_ev = ext_int_line & ~q.int_prev & interrupt_enable_config
             & line_mask;
    d.int_prev = ext_int_line;
    d.booted = 1'b1;
    d.evt = {tmr_hit,
             network_joined,
             (~q.booted) | restart,
             int_ev};
  end

  ////////////////////////////////////////////////////////////////////////
  // factory defaults load on reset
  always_ff @(posedge clock) begin
    if (!rstn) begin
      q <= '0;
      q.act[0] <= `EAD_RST_LINE_A;
      q.act[1] <= `EAD_RST_NONE;
      q.act[2] <= `EAD_RST_NONE;
      for (int i = 0; i < `EAD_NUM_NET_TMR; i++) begin
        q.thr[i] <= `EAD_RST_NET_THR;
        q.act[`EAD_EVT_TMR0 + i] <= `EAD_RST_NET_ACT;
      end
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // timers and dispatch
  ead_tick_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clock (clock),
    .rstn  (rstn),
    .thr   (q.thr),
    .hit   (tmr_hit)
  );

  assign evt_bus.hit = q.evt;
  assign evt_bus.act = q.act;

  ead_event_arbiter u_arb (
    .clock        (clock),
    .rstn         (rstn),
    .ev           (evt_bus.arb),
    .action_valid (action_valid),
    .action_code  (action_code),
    .action_event (action_event)
  );

  assign reg_rdata = q.rdata;
  assign reg_ack   = q.ack;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking

  property p_reset_defaults;
    !rstn |=> q.act[0] == `EAD_RST_LINE_A && q.act[1] == `EAD_RST_NONE
              && q.act[2] == `EAD_RST_NONE;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("action registers not at defaults after reset");

  property p_net_timer_default;
    !rstn |=> q.thr[3] == `EAD_RST_NET_THR
              && q.act[`EAD_EVT_TMR0 + 3] == `EAD_RST_NET_ACT;
  endproperty
  a_net_timer_default: assert property (p_net_timer_default)
    else $error("network timer defaults missing");

  sequence s_line_c_rise;
    !ext_int_line[2] ##1 ext_int_line[2] && interrupt_enable_config[2];
  endsequence

  property p_line_c_masked;
    disable iff (!rstn)
    (long_range_variant && q.booted) throughout s_line_c_rise
      |=> !q.evt[`EAD_EVT_LINE_C];
  endproperty
  a_line_c_masked: assert property (p_line_c_masked)
    else $error("line c event on long range variant");

  property p_int_disabled;
    disable iff (!rstn)
    !interrupt_enable_config[1] |=> !q.evt[1];
  endproperty
  a_int_disabled: assert property (p_int_disabled)
    else $error("disabled interrupt line raised an event");

  property p_boot_event;
    !rstn ##1 rstn |=> q.evt[`EAD_EVT_BOOT];
  endproperty
  a_boot_event: assert property (p_boot_event)
    else $error("no boot event after reset");

  property p_join_event;
    disable iff (!rstn)
    network_joined |=> q.evt[`EAD_EVT_JOIN];
  endproperty
  a_join_event: assert property (p_join_event)
    else $error("network join event missing");

  property p_write_readback;
    disable iff (!rstn)
    reg_wr && reg_sel == `EAD_REG_LINE_D
      ##1 reg_rd && !reg_wr && reg_sel == `EAD_REG_LINE_D
      |=> reg_ack && reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_write_readback: assert property (p_write_readback)
    else $error("action register did not keep written code");

  sequence s_low_quiet;
    (q.evt[5:0] == 6'h00) [*8];
  endsequence

  property p_timer_action;
    disable iff (!rstn)
    s_low_quiet ##0 tmr_hit[0] ##1 q.evt[5:0] == 6'h00
      ##1 q.act[`EAD_EVT_TMR0] != 16'h0000
      |=> action_valid && action_event == 4'(`EAD_EVT_TMR0);
  endproperty
  a_timer_action: assert property (p_timer_action)
    else $error("timer hit did not dispatch its action");

  property p_timer_events;
    disable iff (!rstn)
    tmr_hit != 8'h00 |=> q.evt[13:6] == $past(tmr_hit);
  endproperty
  a_timer_events: assert property (p_timer_events)
    else $error("timer hit not raised as its event");

  property p_ack_follows_strobe;
    disable iff (!rstn)
    reg_wr || reg_rd |=> reg_ack;
  endproperty
  a_ack_follows_strobe: assert property (p_ack_follows_strobe)
    else $error("register access not acknowledged");

  property p_ack_quiet;
    disable iff (!rstn)
    !reg_wr && !reg_rd |=> !reg_ack;
  endproperty
  a_ack_quiet: assert property (p_ack_quiet)
    else $error("acknowledge without register access");

  property p_rdata_quiet;
    disable iff (!rstn)
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data not zero outside a read");

  property p_line_a_read;
    disable iff (!rstn)
    reg_rd && reg_sel == `EAD_REG_LINE_A
      |=> reg_rdata == $past(q.act[0]);
  endproperty
  a_line_a_read: assert property (p_line_a_read)
    else $error("line a action read wrong");

  property p_line_d_write;
    disable iff (!rstn)
    reg_wr && reg_sel == `EAD_REG_LINE_D
      |=> q.act[3] == $past(reg_wdata);
  endproperty
  a_line_d_write: assert property (p_line_d_write)
    else $error("written line d code not taken");

  property p_act_kept;
    disable iff (!rstn)
    !reg_wr |=> $stable(q.act) && $stable(q.thr);
  endproperty
  a_act_kept: assert property (p_act_kept)
    else $error("register changed without a write");

  property p_thr_write;
    disable iff (!rstn)
    reg_wr && reg_sel == `EAD_REG_THR_BASE
      |=> q.thr[0] == $past(reg_wdata);
  endproperty
  a_thr_write: assert property (p_thr_write)
    else $error("timer threshold write not taken");

  property p_thr_read;
    disable iff (!rstn)
    reg_rd && reg_sel == `EAD_REG_THR_BASE
      |=> reg_rdata == $past(q.thr[0]);
  endproperty
  a_thr_read: assert property (p_thr_read)
    else $error("timer threshold read wrong");

  property p_unmapped_write;
    disable iff (!rstn)
    reg_wr && reg_sel > `EAD_REG_ACT_LAST
      |=> $stable(q.act) && $stable(q.thr);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("unmapped write changed a register");

  property p_unmapped_read;
    disable iff (!rstn)
    reg_rd && reg_sel > `EAD_REG_ACT_LAST |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  property p_restart_event;
    disable iff (!rstn)
    restart |=> q.evt[`EAD_EVT_BOOT];
  endproperty
  a_restart_event: assert property (p_restart_event)
    else $error("restart raised no boot event");

  property p_boot_once;
    disable iff (!rstn)
    q.booted && !restart |=> !q.evt[`EAD_EVT_BOOT];
  endproperty
  a_boot_once: assert property (p_boot_once)
    else $error("boot event without restart");

  sequence s_line_a_rise;
    !ext_int_line[0] ##1 ext_int_line[0] && interrupt_enable_config[0];
  endsequence

  property p_line_a_event;
    disable iff (!rstn)
    s_line_a_rise |=> q.evt[0];
  endproperty
  a_line_a_event: assert property (p_line_a_event)
    else $error("enabled line a edge raised no event");

  property p_level_no_event;
    disable iff (!rstn)
    ext_int_line[0] ##1 ext_int_line[0] |=> !q.evt[0];
  endproperty
  a_level_no_event: assert property (p_level_no_event)
    else $error("steady line a level raised an event");
endmodule

// [bench/ead_pin_model.sv]
// pulse driver standing in for the external interrupt pins
`timescale 1ns/1ps
module ead_pin_model (
  input  wire logic       clock,
  input  wire logic [3:0] fire,
  output logic [3:0]      pin
);
  logic [1:0] hold_q [4] = '{default: 2'h0};
  // each request holds its line high for three cycles
  always_ff @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (fire[i])
        hold_q[i] <= 2'h3;
      else if (hold_q[i] != 2'h0)
        hold_q[i] <= hold_q[i] - 2'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++)
      pin[i] = (hold_q[i] != 2'h0);
  end
endmodule

// [bench/event_action_dispatcher_bench.sv]
// self-checking bench of the event action dispatcher
`timescale 1ns/1ps
module event_action_dispatcher_bench;
  localparam int unsigned TICK = 20;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  fire = 4'h0;
  logic [3:0]  ext_int_line;
  logic [3:0]  int_en = 4'h0;
  logic        lrv = 1'b0;
  logic        restart = 1'b0;
  logic        joined = 1'b0;
  logic [7:0]  reg_sel = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic        reg_ack;
  logic        action_valid;
  logic [15:0] action_code;
  logic [3:0]  action_event;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          seen [14] = '{default: 0};
  int          last_t [14];
  logic [15:0] last_code [14];
  logic [15:0] rd;
  logic [15:0] code;
  int          t0;
  int          thr;
  ////////////////////////////////////////////////////////////
  event_action_dispatcher #(.TICK_CYCLES(TICK)) i_event_action_dispatcher (
    .clock                   (clock),
    .rstn                    (rstn),
    .ext_int_line            (ext_int_line),
    .interrupt_enable_config (int_en),
    .long_range_variant      (lrv),
    .restart                 (restart),
    .network_joined          (joined),
    .reg_sel                 (reg_sel),
    .reg_wr                  (reg_wr),
    .reg_rd                  (reg_rd),
    .reg_wdata               (reg_wdata),
    .reg_rdata               (reg_rdata),
    .reg_ack                 (reg_ack),
    .action_valid            (action_valid),
    .action_code             (action_code),
    .action_event            (action_event)
  );
  ead_pin_model i_ead_pin_model (
    .clock (clock),
    .fire  (fire),
    .pin   (ext_int_line)
  );
  initial begin
    forever #2.5 clock = ~clock;
  end
  // action monitor
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (action_valid === 1'b1) begin
      seen[action_event] <= seen[action_event] + 1;
      last_code[action_event] <= action_code;
      last_t[action_event] <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_period(input int t);
    return 16'(t * TICK);
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic reg_write(input logic [7:0] sel, input logic [15:0] d);
    reg_sel = sel;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask
  task automatic reg_read(input logic [7:0] sel, output logic [15:0] q);
    reg_sel = sel;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    q = (reg_ack === 1'b1) ? reg_rdata : 16'hDEAD;
    step(1);
  endtask
  task automatic reg_write_read(input logic [7:0] sel,
                                input logic [15:0] d,
                                output logic [15:0] q);
    reg_sel = sel;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    q = (reg_ack === 1'b1) ? reg_rdata : 16'hDEAD;
    step(1);
  endtask
  task automatic wait_evt(input int e, input logic [15:0] exp);
    int n;
    int k;
    n = seen[e];
    k = 0;
    while (seen[e] == n && k < 300) begin
      step(1);
      k++;
    end
    if (k == 300) begin
      fail_count++;
      $display("mismatch event %0d expected action seen none", e);
      complete_run();
    end
    check("action code", exp, last_code[e]);
  endtask
  task automatic no_evt(input int e);
    int n;
    n = seen[e];
    step(100);
    check("action count", 16'(n), 16'(seen[e]));
  endtask
  task automatic pulse(input int i);
    fire[i] = 1'b1;
    step(1);
    fire[i] = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(11));
    step(5);
    rstn = 1'b1;
    int_en = 4'hF;
    wait_evt(6, 16'h0001);
    reg_read(8'h23, rd);
    check("line a action", 16'h0001, rd);
    for (int i = 1; i < 3; i++) begin
      reg_read(8'(8'h23 + i), rd);
      check("line action", 16'h0000, rd);
    end
    reg_read(8'h29, rd);
    check("timer threshold", 16'h0004, rd);
    reg_write(8'h50, 16'hA5A5);
    reg_read(8'h50, rd);
    check("unmapped", 16'h0000, rd);
    for (int i = 0; i < 4; i++)
      reg_write(8'(8'h29 + i), 16'h0000);
    no_evt(6);
    pulse(0);
    wait_evt(0, 16'h0001);
    for (int i = 1; i < 4; i++) begin
      code = 16'($urandom_range(16'hFFFF, 1));
      reg_write_read(8'(8'h23 + i), code, rd);
      check("action readback", code, rd);
      pulse(i);
      wait_evt(i, code);
    end
    lrv = 1'b1;
    pulse(2);
    no_evt(2);
    lrv = 1'b0;
    int_en = 4'hD;
    pulse(1);
    no_evt(1);
    int_en = 4'hF;
    reg_write(8'h24, 16'h0000);
    pulse(1);
    no_evt(1);
    code = 16'($urandom_range(16'hFFFF, 1));
    reg_write(8'h27, code);
    restart = 1'b1;
    step(1);
    restart = 1'b0;
    wait_evt(4, code);
    reg_read(8'h27, rd);
    check("boot action kept", code, rd);
    code = 16'($urandom_range(16'hFFFF, 1));
    reg_write(8'h28, code);
    joined = 1'b1;
    step(1);
    joined = 1'b0;
    wait_evt(5, code);
    thr = int'($urandom_range(3, 1));
    code = 16'($urandom_range(16'hFFFF, 1));
    reg_write(8'h35, code);
    reg_write(8'h2D, 16'(thr));
    wait_evt(10, code);
    t0 = last_t[10];
    wait_evt(10, code);
    check("timer period", exp_period(thr), 16'(last_t[10] - t0));
    complete_run();
  end
endmodule
